// *** tsc_pkg.sv ***
// Purpose: constants shared by the transport sample checker files
// Assumes: 8-bit register port, 16-bit samples
// Notes: offsets are byte addresses on the plain register port
package tsc_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int SAMPLE_W = 16;
	localparam int NUM_POS = 16;
	localparam int NUM_SUB = 3;
	localparam int POS_W = 4;
	localparam int SUB_W = 2;
	// register offsets
	localparam logic [11:0] OFF_CONTROL = 12'h32C;
	localparam logic [11:0] OFF_REF_LOW = 12'h32D;
	localparam logic [11:0] OFF_REF_HIGH = 12'h32E;
	localparam logic [11:0] OFF_RESULT = 12'h32F;
	localparam logic [11:0] OFF_IRQ_STATUS = 12'h330;
	localparam logic [11:0] OFF_IRQ_MASK = 12'h331;
	// control field positions
	localparam int CTL_POS_MSB = 7;
	localparam int CTL_POS_LSB = 4;
	localparam int CTL_SUB_MSB = 3;
	localparam int CTL_SUB_LSB = 2;
	localparam int CTL_CLEAR_BIT = 1;
	localparam int CTL_ENABLE_BIT = 0;
	// result register field positions
	localparam int RES_IQ_BIT = 6;
	localparam int RES_FAIL_BIT = 0;
	// interrupt status bits
	localparam int IRQ_W = 2;
	localparam int IRQ_FAIL_BIT = 0;
	localparam int IRQ_CHECKED_BIT = 1;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [1:0] SUB_MAX = 2'h2;
endpackage

// *** tsc_sample_select.sv ***
// Purpose: picks one sample out of the receiver output word
// Assumes: samples packed per subchannel, per position, I then Q
// Notes: registered output, one cycle of latency
`timescale 1ns/1ps
`default_nettype none
module tsc_sample_select
	import tsc_pkg::*;
#(
	parameter int NPOS = NUM_POS,
	parameter int NSUB = NUM_SUB,
	parameter int SW = SAMPLE_W
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [NSUB*NPOS*2*SW-1:0] rx_samples,
	input wire logic rx_valid,
	input wire logic [POS_W-1:0] pos,
	input wire logic [SUB_W-1:0] sub,
	input wire logic iq,
	output logic [SW-1:0] sample,
	output logic sample_valid
);
	logic [SW-1:0] lanes [NSUB*NPOS*2];
	logic [SW-1:0] next_sample;
	logic next_valid;

	// --------------------------------------------------------------
	// unpack the flat word into one entry per sample
	// --------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NSUB*NPOS*2; g++) begin : gen_unpack
			assign lanes[g] = rx_samples[g*SW +: SW];
		end
	endgenerate

	// mux; an unused subchannel code never yields a valid sample
	always_comb begin
		next_sample = sample;
		next_valid = 1'b0;
		if (rx_valid && sub < SUB_W'(NSUB)) begin
			next_sample = lanes[(int'(sub)*NPOS + int'(pos))*2 + int'(iq)];
			next_valid = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sample <= '0;
			sample_valid <= 1'b0;
		end else begin
			sample <= next_sample;
			sample_valid <= next_valid;
		end
	end
endmodule
`default_nettype wire

// *** tsc_irq.sv ***
// Purpose: sticky interrupt status with mask and write-one-clear
// Assumes: set and clear arrive on the same clock
// Notes: set beats clear in the same cycle so no event is lost
`timescale 1ns/1ps
`default_nettype none
module tsc_irq
	import tsc_pkg::*;
#(
	parameter int W = IRQ_W
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [W-1:0] set,
	input wire logic [W-1:0] clear,
	input wire logic [W-1:0] mask_in,
	input wire logic mask_we,
	output logic [W-1:0] status,
	output logic [W-1:0] mask,
	output logic irq
);
	logic [W-1:0] next_status;
	logic [W-1:0] next_mask;

	// set wins over write-one-clear
	always_comb begin
		next_status = (status & ~clear) | set;
		next_mask = mask_we ? mask_in : mask;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			status <= '0;
			mask <= '0;
		end else begin
			status <= next_status;
			mask <= next_mask;
		end
	end

	assign irq = |(status & mask);
endmodule
`default_nettype wire

// *** transport_sample_checker.sv ***
// Purpose: transport layer sample self-test checker
// Assumes: receiver output arrives on clk as a flat word with a valid
// Notes: register port is byte wide, read data one cycle after strobe
//   the fail flag lands two cycles after the receiver valid that carried it
//   a selection change drops the one picked sample already in flight
//
// Behaviour
// - control bits 7:4 choose which of sixteen sample positions is checked
// - control bits 3:2 choose channelizer subchannel 0, 1 or 2
// - writing one to control bit 1 clears the stored result
// - compare runs only while control bit 0 is one; controls reset zero
// - expected sample low byte lives at 0x32D
// - expected sample high byte lives at 0x32E above the low byte
// - compare the reference against the raw receiver output sample
// - read-only fail flag: zero pass, one mismatch
// - one bit picks I or Q path, zero is I
`timescale 1ns/1ps
`default_nettype none
module transport_sample_checker
	import tsc_pkg::*;
#(
	parameter int NPOS = NUM_POS,
	parameter int NSUB = NUM_SUB,
	parameter int SW = SAMPLE_W
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [DATA_W-1:0] reg_rdata,
	input wire logic [NSUB*NPOS*2*SW-1:0] rx_samples,
	input wire logic rx_valid,
	output logic check_mismatch_flag,
	output logic irq
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN = 2'b10
	} check_state_t;

	// --------------------------------------------------------------
	// register state
	// --------------------------------------------------------------
	// software-visible control fields
	logic [POS_W-1:0] check_sample_position;
	logic [SUB_W-1:0] check_subchannel_select;
	logic check_enable;
	logic check_iq_path_select;
	logic [DATA_W-1:0] expected_sample_low;
	logic [DATA_W-1:0] expected_sample_high;
	// next values, one per control field
	logic [POS_W-1:0] next_position;
	logic [SUB_W-1:0] next_subchannel;
	logic next_enable;
	logic next_iq;
	logic [DATA_W-1:0] next_ref_low;
	logic [DATA_W-1:0] next_ref_high;
	// decoded write strobes, one per register plus the control clear bit strobe
	logic check_result_clear;
	logic wr_control;
	logic wr_result;
	logic wr_low;
	logic wr_high;
	logic wr_status;
	logic wr_mask;

	// address decode; strobes are single cycle
	always_comb begin
		wr_control = reg_write && reg_addr == OFF_CONTROL;
		wr_low = reg_write && reg_addr == OFF_REF_LOW;
		wr_high = reg_write && reg_addr == OFF_REF_HIGH;
		wr_result = reg_write && reg_addr == OFF_RESULT;
		wr_status = reg_write && reg_addr == OFF_IRQ_STATUS;
		wr_mask = reg_write && reg_addr == OFF_IRQ_MASK;
		check_result_clear = wr_control && reg_wdata[CTL_CLEAR_BIT];
	end

	// next values of the software controls
	always_comb begin
		next_position = check_sample_position;
		next_subchannel = check_subchannel_select;
		next_enable = check_enable;
		next_iq = check_iq_path_select;
		next_ref_low = expected_sample_low;
		next_ref_high = expected_sample_high;
		if (wr_control) begin
			next_position = reg_wdata[CTL_POS_MSB:CTL_POS_LSB];
			next_subchannel = reg_wdata[CTL_SUB_MSB:CTL_SUB_LSB];
			next_enable = reg_wdata[CTL_ENABLE_BIT];
		end
		if (wr_result) begin
			next_iq = reg_wdata[RES_IQ_BIT];
		end
		if (wr_low) begin
			next_ref_low = reg_wdata;
		end
		if (wr_high) begin
			next_ref_high = reg_wdata;
		end
	end

	// all controls reset to zero
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			check_sample_position <= '0;
			check_subchannel_select <= '0;
			check_enable <= 1'b0;
			check_iq_path_select <= 1'b0;
			expected_sample_low <= RESET_BYTE;
			expected_sample_high <= RESET_BYTE;
		end else begin
			check_sample_position <= next_position;
			check_subchannel_select <= next_subchannel;
			check_enable <= next_enable;
			check_iq_path_select <= next_iq;
			expected_sample_low <= next_ref_low;
			expected_sample_high <= next_ref_high;
		end
	end

	// --------------------------------------------------------------
	// sample pick and compare
	// --------------------------------------------------------------
	// selected sample and the assembled reference
	logic [SW-1:0] picked;
	logic picked_valid;
	logic [SW-1:0] reference;

	// taps the raw receiver word, ahead of any datapath processing
	tsc_sample_select #(
		.NPOS(NPOS),
		.NSUB(NSUB),
		.SW(SW)
	) u_select (
		.clk(clk),
		.resetn(resetn),
		.rx_samples(rx_samples),
		.rx_valid(rx_valid),
		.pos(check_sample_position),
		.sub(check_subchannel_select),
		.iq(check_iq_path_select),
		.sample(picked),
		.sample_valid(picked_valid)
	);

	assign reference = {expected_sample_high, expected_sample_low};

	// --------------------------------------------------------------
	// selection change guard
	// --------------------------------------------------------------
	logic select_stale;
	logic next_select_stale;

	// the pick already registered used the old selection, so one sample
	// after a change is dropped; a plain clear or enable write keeps it
	always_comb begin
		next_select_stale = 1'b0;
		if (wr_control && (next_position != check_sample_position
			|| next_subchannel != check_subchannel_select)) begin
			next_select_stale = 1'b1;
		end
		if (wr_result && next_iq != check_iq_path_select) begin
			next_select_stale = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			select_stale <= 1'b0;
		end else begin
			select_stale <= next_select_stale;
		end
	end

	// --------------------------------------------------------------
	// compare and sticky result
	// --------------------------------------------------------------

	check_state_t state;
	check_state_t next_state;
	logic next_flag;
	logic mismatch_event;
	logic compare_event;

	// state follows the enable; a compare lands only while running
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (check_enable) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!check_enable) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		compare_event = state == ST_RUN && check_enable && picked_valid && !select_stale;
		mismatch_event = compare_event && picked != reference;
		// sticky; a mismatch in the clear cycle still sets the flag
		next_flag = check_mismatch_flag;
		if (check_result_clear) begin
			next_flag = 1'b0;
		end
		if (mismatch_event) begin
			next_flag = 1'b1;
		end
	end

	// flag and state share one reset so a stale fail never survives it
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state <= ST_IDLE;
			check_mismatch_flag <= 1'b0;
		end else begin
			state <= next_state;
			check_mismatch_flag <= next_flag;
		end
	end

	// --------------------------------------------------------------
	// interrupts
	// --------------------------------------------------------------
	logic [IRQ_W-1:0] irq_set;
	logic [IRQ_W-1:0] irq_status;
	logic [IRQ_W-1:0] irq_mask;
	logic [IRQ_W-1:0] irq_clear;

	// event pulses and write-one-clear mask for the sticky status
	always_comb begin
		irq_set = '0;
		irq_set[IRQ_FAIL_BIT] = mismatch_event;
		irq_set[IRQ_CHECKED_BIT] = compare_event;
		irq_clear = '0;
		if (wr_status) begin
			irq_clear = reg_wdata[IRQ_W-1:0];
		end
	end

	// status and mask live in the small sticky block
	tsc_irq #(
		.W(IRQ_W)
	) u_irq (
		.clk(clk),
		.resetn(resetn),
		.set(irq_set),
		.clear(irq_clear),
		.mask_in(reg_wdata[IRQ_W-1:0]),
		.mask_we(wr_mask),
		.status(irq_status),
		.mask(irq_mask),
		.irq(irq)
	);

	// --------------------------------------------------------------
	// read port
	// --------------------------------------------------------------
	logic [DATA_W-1:0] next_rdata;

	// unmapped addresses and idle cycles read as zero
	always_comb begin
		next_rdata = '0;
		if (reg_read) begin
			case (reg_addr)
				OFF_CONTROL: begin
					next_rdata[CTL_POS_MSB:CTL_POS_LSB] = check_sample_position;
					next_rdata[CTL_SUB_MSB:CTL_SUB_LSB] = check_subchannel_select;
					next_rdata[CTL_ENABLE_BIT] = check_enable; // clear bit reads 0
				end
				OFF_REF_LOW: begin
					next_rdata = expected_sample_low;
				end
				OFF_REF_HIGH: begin
					next_rdata = expected_sample_high;
				end
				OFF_RESULT: begin
					next_rdata[RES_IQ_BIT] = check_iq_path_select;
					next_rdata[RES_FAIL_BIT] = check_mismatch_flag;
				end
				OFF_IRQ_STATUS: begin
					next_rdata[IRQ_W-1:0] = irq_status;
				end
				OFF_IRQ_MASK: begin
					next_rdata[IRQ_W-1:0] = irq_mask;
				end
				default: begin
					next_rdata = '0;
				end
			endcase
		end
	end

	// read data stand one cycle only, then fall back to zero
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= next_rdata;
		end
	end
endmodule
`default_nettype wire

// *** tsc_tx_model.sv ***
// Purpose: behavioural transmitter feeding the receiver output word
// Assumes: sample k carries 16'h5A00 plus k unless it is the injected one
// Notes: one frame per send pulse, no back pressure
`timescale 1ns/1ps
`default_nettype none
module tsc_tx_model
	import tsc_pkg::*;
#(
	parameter int NS = NUM_SUB*NUM_POS*2
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic send,
	input wire logic [6:0] bad_idx,
	input wire logic [15:0] bad_val,
	output logic [NS*SAMPLE_W-1:0] rx_samples,
	output logic rx_valid
);
	// ------------------------------
	// frame generation
	// ------------------------------
	// between frames the word flips so stale data never poses as a match
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rx_valid <= 1'b0;
			rx_samples <= '0;
		end else begin
			rx_valid <= send;
			for (int k = 0; k < NS; k++) begin
				if (!send)
					rx_samples[k*16+:16] <= ~rx_samples[k*16+:16];
				else if (k == int'(bad_idx))
					rx_samples[k*16+:16] <= bad_val;
				else
					rx_samples[k*16+:16] <= 16'(16'h5A00 + k);
			end
		end
	end
endmodule
`default_nettype wire

// *** tsc_checks_assertions.sv ***
// Purpose: port-level checks of the transport sample checker
// Assumes: one clock domain, async active-low reset
// Notes: flag lands two cycles after the valid that caused it
`timescale 1ns/1ps
`default_nettype none
module tsc_checks
	import tsc_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [DATA_W-1:0] reg_rdata,
	input wire logic rx_valid,
	input wire logic check_mismatch_flag,
	input wire logic irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// ------------------------------
	// properties
	// ------------------------------
	logic clr_wr;
	assign clr_wr = reg_write && reg_addr == OFF_CONTROL && reg_wdata[CTL_CLEAR_BIT];
	property p_flag_hold;
		check_mismatch_flag && !clr_wr |=> check_mismatch_flag;
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("fail flag dropped");
	property p_flag_fall;
		$fell(check_mismatch_flag) |-> $past(clr_wr);
	endproperty
	a_flag_fall: assert property (p_flag_fall) else $error("flag fell without clear");
	// quiet pipeline needed, a late mismatch wins over the clear
	property p_clear;
		clr_wr && !$past(rx_valid) && !$past(rx_valid, 2) |=> !check_mismatch_flag;
	endproperty
	a_clear: assert property (p_clear) else $error("clear ignored");
	property p_rise_cause;
		$rose(check_mismatch_flag) |-> $past(rx_valid, 2);
	endproperty
	a_rise_cause: assert property (p_rise_cause) else $error("flag rose without sample");
	property p_result_read;
		reg_read && reg_addr == OFF_RESULT |=>
			reg_rdata[0] == $past(check_mismatch_flag) && reg_rdata[5:1] == 5'h00;
	endproperty
	a_result_read: assert property (p_result_read) else $error("result read wrong");
	property p_ctrl_read;
		reg_read && reg_addr == OFF_CONTROL |=> !reg_rdata[CTL_CLEAR_BIT];
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) else $error("clear bit read back");
	property p_ref_rw;
		reg_write && (reg_addr == OFF_REF_LOW || reg_addr == OFF_REF_HIGH) ##1 !reg_write
			##1 reg_read && reg_addr == $past(reg_addr, 2) |=> reg_rdata == $past(reg_wdata, 3);
	endproperty
	a_ref_rw: assert property (p_ref_rw) else $error("reference byte lost");
	property p_irq_rise;
		$rose(irq) |-> $past(rx_valid, 2) || $past(reg_write);
	endproperty
	a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
	c_flag: cover property ($rose(check_mismatch_flag));
	c_clear: cover property ($fell(check_mismatch_flag));
	c_irq: cover property ($rose(irq));
endmodule
bind transport_sample_checker tsc_checks u_checks (.clk, .resetn, .reg_addr, .reg_wdata,
	.reg_write, .reg_read, .reg_rdata, .rx_valid, .check_mismatch_flag, .irq);
`default_nettype wire

// *** transport_sample_checker_tb.sv ***
// Purpose: register-driven test of the transport sample checker
// Assumes: transmitter model pattern 16'h5A00 plus sample index
// Notes: the four-cycle wait after a frame covers the fixed two-cycle flag latency
`timescale 1ns/1ps
`default_nettype none
module transport_sample_checker_tb
	import tsc_pkg::*;
();
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [DATA_W-1:0] reg_rdata;
	logic [NUM_SUB*NUM_POS*2*SAMPLE_W-1:0] rx_samples;
	logic rx_valid, check_mismatch_flag, irq;
	logic send = 1'b0;
	logic [6:0] bad_idx = '0;
	logic [15:0] bad_val = '0;
	logic [6:0] idx;
	logic [15:0] exp_s;
	logic [11:0] offs [7] = '{OFF_CONTROL, OFF_REF_LOW, OFF_REF_HIGH, OFF_RESULT,
		OFF_IRQ_STATUS, OFF_IRQ_MASK, 12'h000};
	int failures = 0;
	int check_count = 0;
	int cyc = 0;
	always #4 clk = ~clk;
	transport_sample_checker dut (.clk, .resetn, .reg_addr, .reg_wdata, .reg_write,
		.reg_read, .reg_rdata, .rx_samples, .rx_valid, .check_mismatch_flag, .irq);
	tsc_tx_model tx (.clk, .resetn, .send, .bad_idx, .bad_val, .rx_samples, .rx_valid);
	// ------------------------------
	// bus and frame tasks
	// ------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_read <= 1'b0;
		#1;
		chk({8'h00, reg_rdata}, {8'h00, e});
	endtask
	task automatic frame(input logic [6:0] i, input logic [15:0] v, input logic e);
		@(posedge clk);
		send <= 1'b1;
		bad_idx <= i;
		bad_val <= v;
		@(posedge clk);
		send <= 1'b0;
		repeat (4) @(posedge clk);
		#1;
		chk({15'h0, check_mismatch_flag}, {15'h0, e});
	endtask
	task automatic tally_and_finish;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// hang guard, generous beside a run of under a thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			tally_and_finish;
		end
	end
	// ------------------------------
	// scenarios
	// ------------------------------
	initial begin
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		foreach (offs[j]) rd(offs[j], 8'h00);
		wr(OFF_REF_LOW, 8'hC3);
		rd(OFF_REF_LOW, 8'hC3);
		wr(OFF_REF_HIGH, 8'h3C);
		rd(OFF_REF_HIGH, 8'h3C);
		wr(OFF_IRQ_MASK, 8'h01);
		// every subchannel, edge positions, both paths
		for (int s = 0; s < 3; s++) begin
			for (int p = 0; p < 16; p += 15) begin
				for (int q = 0; q < 2; q++) begin
					idx = 7'((s*16+p)*2+q);
					exp_s = 16'h5A00 + 16'(idx);
					wr(OFF_REF_LOW, exp_s[7:0]);
					wr(OFF_REF_HIGH, exp_s[15:8]);
					wr(OFF_RESULT, {1'b0, q[0], 6'h00});
					wr(OFF_CONTROL, {p[3:0], s[1:0], 2'b01});
					frame(idx, exp_s, 1'b0);
					frame(idx ^ 7'h01, 16'hFFFF, 1'b0);
					frame(idx, ~exp_s, 1'b1);
					frame(idx, exp_s, 1'b1);
					rd(OFF_RESULT, {1'b0, q[0], 6'h01});
					wr(OFF_CONTROL, {p[3:0], s[1:0], 2'b11});
					frame(idx, exp_s, 1'b0);
					wr(OFF_IRQ_STATUS, 8'h03);
				end
			end
		end
		// interrupt raised, masked off, then cleared
		wr(OFF_CONTROL, 8'h01);
		frame(7'h00, 16'h0000, 1'b1);
		chk({15'h0, irq}, 16'h0001);
		rd(OFF_IRQ_STATUS, 8'h03);
		wr(OFF_IRQ_MASK, 8'h00);
		// the mask lands at the edge that ended the write; look once settled
		#1;
		chk({15'h0, irq}, 16'h0000);
		wr(OFF_IRQ_STATUS, 8'h03);
		rd(OFF_IRQ_STATUS, 8'h00);
		// disabled check and subchannel code 3 never flag
		wr(OFF_CONTROL, 8'h02);
		frame(7'h00, 16'h0000, 1'b0);
		wr(OFF_CONTROL, 8'h0F);
		rd(OFF_CONTROL, 8'h0D);
		frame(7'h00, 16'h0000, 1'b0);
		tally_and_finish;
	end
endmodule
`default_nettype wire
